/* File: rfmpc_pkg.sv */
/*
 rfmpc_pkg: constants for the rf modem packet control block.
 assumes a 50 MHz system clock and a 16-bit parameter write port.
*/
package rfmpc_pkg;
   // ==========================================
   // parameter selectors
   localparam logic [3:0] SEL_WAKE_INIT = 4'h0;
   localparam logic [3:0] SEL_ADDR_MASK = 4'h1;
   localparam logic [3:0] SEL_FORCED_RETX = 4'h2;
   localparam logic [3:0] SEL_SRC_ADDR = 4'h3;
   localparam logic [3:0] SEL_PARITY = 4'h4;
   localparam logic [3:0] SEL_MAX_PKT = 4'h5;
   localparam logic [3:0] SEL_TX_POWER = 4'h6;
   localparam logic [3:0] SEL_PIN_WAKE = 4'h7;
   localparam logic [3:0] SEL_THRESHOLD = 4'h8;
   localparam logic [3:0] SEL_SILENCE = 4'h9;
   localparam logic [3:0] SEL_RETRY = 4'ha;
   localparam logic [3:0] SEL_BACKOFF = 4'hb;
   localparam logic [3:0] SEL_DATA_RATE = 4'hc;
   localparam logic [3:0] SEL_DEST_ADDR = 4'hd;
   localparam logic [3:0] SEL_IDLE_SLEEP = 4'he;
   localparam logic [3:0] SEL_SLEEP_MODE = 4'hf;
   // ==========================================
   // reset values
   localparam logic [7:0] RST_WAKE_INIT = 8'h01;
   localparam logic [15:0] RST_ADDR_MASK = 16'hffff;
   localparam logic [7:0] RST_FORCED_RETX = 8'h00;
   localparam logic [15:0] RST_SRC_ADDR = 16'hffff;
   localparam logic [7:0] RST_PARITY = 8'h00;
   localparam logic [15:0] RST_MAX_PKT = 16'h0800;
   localparam logic [7:0] RST_TX_POWER = 8'h04;
   localparam logic [7:0] RST_PIN_WAKE = 8'h00;
   localparam logic [15:0] RST_THRESHOLD = 16'h0800;
   localparam logic [15:0] RST_SILENCE = 16'h0003;
   localparam logic [7:0] RST_RETRY = 8'h0a;
   localparam logic [7:0] RST_BACKOFF = 8'h00;
   localparam logic [7:0] RST_DATA_RATE = 8'h01;
   localparam logic [15:0] RST_DEST_ADDR = 16'h0000;
   localparam logic [15:0] RST_IDLE_SLEEP = 16'h0064;
   localparam logic [7:0] RST_SLEEP_MODE = 8'h00;
   // ==========================================
   // limits
   localparam logic [15:0] PKT_CAP_LOW = 16'h0100;
   localparam logic [15:0] PKT_CAP_HIGH = 16'h0800;
   localparam logic [7:0] PARITY_MAX = 8'h04;
   localparam logic [7:0] POWER_MAX = 8'h04;
   localparam logic [7:0] SLEEP_CYCLIC_MIN = 8'h04;
   localparam logic [7:0] SLEEP_CYCLIC_MAX = 8'h08;
   // ==========================================
   // timing
   localparam int CLK_HZ = 50000000;
   localparam int WAKE_UNIT_MS = 100;
   localparam int WAKE_DETECT_MS = 35;
   localparam int SLOT_MS = 38;
   localparam int MS_CYCLES = CLK_HZ / 1000;
   localparam int WAKE_UNIT_CYCLES = WAKE_UNIT_MS * MS_CYCLES;
   localparam int WAKE_DETECT_CYCLES = WAKE_DETECT_MS * MS_CYCLES;
   localparam int SLOT_CYCLES = SLOT_MS * MS_CYCLES;
   // ==========================================
   // transmit states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_WAKE = 3'b001,
      TX_SEND = 3'b011,
      TX_GAP = 3'b010,
      TX_HOLD = 3'b110
   } rfmpc_tx_e;
endpackage

/* File: rfmpc_top.sv */
/*
 rfmpc_top: packet control of a frequency-hopping rf modem: parameter store,
 transmit start/streaming, forced retransmission, receive address filter,
 burst backoff, wake initializer and pin wake.
 assumes byte-level serial input and rf receive framing arrive as strobes
 synchronous to sys_clk; the rf modulator paces bytes with rfByteTaken.
*/
// Summary of operation
// - wake initializer lasts wake duration times 100 ms; 8 bits, default 1.
// - cyclic-sleep receiver stays awake only after about 35 ms of initializer.
// - destination AND mask must equal own destination or mask, else discard.
// - address mask is 16 bits, default all ones.
// - zero bits in the comparison are don't-care positions.
// - forced count N sends every packet N+1 times, no acknowledgement request.
// - forced count and retry limit both non-zero: forced retransmission wins.
// - overheard pending retransmissions: hold off burst time, plus random slots.
// - source address 16 bits default 0xffff; then destination serves both roles.
// - parity select 0 to 4: none, even, odd, mark, space; default 0.
// - max packet size 0 to 0x800, default 0x800, limits each packet.
// - size above 256 and data rate set to 0: lower to 256, warn.
// - size capped at 0x100 for data rate 0, 0x800 for data rate 1.
// - threshold never exceeds packet size; lowered with it automatically.
// - start when buffer holds data and silence or threshold met; zero ignored.
// - criteria gate first packet only; rest streams without draining first.
// - tx power 0 to 4 means 1, 10, 100, 500, 1000 mW; default 4.
// - pin wake enabled and sleep pin low: no cyclic sleep, fully operational.
// - after sleep pin asserted stay active idle time, then sleep if nothing pending.
// - pin wake has effect only with a cyclic sleep mode enabled.
// - restore defaults resets every parameter, without saving to non-volatile store.
// - each random backoff slot lasts 38 ms.
`timescale 1ns/1ps
module rfmpc_top
   import rfmpc_pkg::*;
#(
   parameter int WAKE_UNIT = WAKE_UNIT_CYCLES,
   parameter int WAKE_DETECT = WAKE_DETECT_CYCLES,
   parameter int SLOT = SLOT_CYCLES,
   parameter int MS_TICK = MS_CYCLES,
   parameter int CHAR_CYCLES = 5208
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic cfgWrite,
   input wire logic [3:0] cfgSel,
   input wire logic [15:0] cfgData,
   input wire logic [3:0] cfgReadSel,
   input wire logic factoryDefaultLoad,
   output logic [15:0] cfgReadData,
   output logic [7:0] warningFlags,
   input wire logic serialByteValid,
   input wire logic [7:0] serialByte,
   output logic serialReady,
   output logic rfByteValid,
   output logic [7:0] rfByte,
   output logic rfPacketStart,
   output logic rfPacketEnd,
   output logic rfAckRequest,
   output logic rfWakeInit,
   output logic [15:0] rfSourceAddr,
   output logic [15:0] rfDestAddr,
   output logic [7:0] rfRetxRemaining,
   input wire logic rfByteTaken,
   input wire logic rxHeader,
   input wire logic [15:0] rxDestAddr,
   input wire logic [7:0] rxRetxRemaining,
   input wire logic [15:0] rxLength,
   input wire logic rxWakeInit,
   output logic rxForward,
   output logic rxDiscard,
   input wire logic sleepPin,
   output logic stayAwake,
   output logic cyclicSleep,
   output logic [2:0] uartParityMode,
   output logic [2:0] txPowerLevel
);
   import rfmpc_pkg::*;
   localparam int DEPTH = 4096;
   localparam bit BAD_TIMING = WAKE_UNIT < 1 || WAKE_DETECT < 1 || SLOT < 1 || MS_TICK < 1 ||
                               CHAR_CYCLES < 1;
   // refuse counts that would leave a timer unable to expire
   if (BAD_TIMING) begin : g_bad_timing
      $error("rfmpc_top: timing counts must be at least one");
   end

   // ==========================================
   // parameter store
   logic [7:0] wakeInitDuration, forcedRetransmitCount, pinWakeEnable, retryLimit;
   logic [7:0] uartParitySelect, txPower, backoffSlotCount, rfDataRate, sleepModeSelect;
   logic [15:0] addressMask, sourceAddress, maxPacketSize, packetizeByteThreshold;
   logic [15:0] packetizeSilenceTimeout, destinationAddress, idleTimeBeforeSleep;
   wire wr = cfgWrite && !factoryDefaultLoad;
   wire [7:0] wr8 = cfgData[7:0];
   wire [15:0] pktCap = (rfDataRate == 8'h00) ? PKT_CAP_LOW : PKT_CAP_HIGH;
   wire [15:0] pktReq = (cfgData > pktCap) ? pktCap : cfgData;
   wire rateToZero = wr && cfgSel == SEL_DATA_RATE && !wr8[0];
   wire [15:0] next_pkt = (rateToZero && maxPacketSize > PKT_CAP_LOW) ? PKT_CAP_LOW :
                          (wr && cfgSel == SEL_MAX_PKT) ? pktReq : maxPacketSize;
   wire [15:0] thrReq = (wr && cfgSel == SEL_THRESHOLD) ? cfgData : packetizeByteThreshold;
   wire [15:0] next_thr = (thrReq > next_pkt) ? next_pkt : thrReq;

   always_ff @(posedge sys_clk) begin
      if (!rstn || factoryDefaultLoad) begin
         wakeInitDuration <= RST_WAKE_INIT;
         addressMask <= RST_ADDR_MASK;
         forcedRetransmitCount <= RST_FORCED_RETX;
         sourceAddress <= RST_SRC_ADDR;
         uartParitySelect <= RST_PARITY;
         maxPacketSize <= RST_MAX_PKT;
         txPower <= RST_TX_POWER;
         pinWakeEnable <= RST_PIN_WAKE;
         packetizeByteThreshold <= RST_THRESHOLD;
         packetizeSilenceTimeout <= RST_SILENCE;
         retryLimit <= RST_RETRY;
         backoffSlotCount <= RST_BACKOFF;
         rfDataRate <= RST_DATA_RATE;
         destinationAddress <= RST_DEST_ADDR;
         idleTimeBeforeSleep <= RST_IDLE_SLEEP;
         sleepModeSelect <= RST_SLEEP_MODE;
      end else begin
         maxPacketSize <= next_pkt;
         packetizeByteThreshold <= next_thr;
         if (wr) begin
            unique case (cfgSel)
               SEL_WAKE_INIT: wakeInitDuration <= wr8;
               SEL_ADDR_MASK: addressMask <= cfgData;
               SEL_FORCED_RETX: forcedRetransmitCount <= wr8;
               SEL_SRC_ADDR: sourceAddress <= cfgData;
               SEL_PARITY: if (wr8 <= PARITY_MAX) uartParitySelect <= wr8;
               SEL_TX_POWER: if (wr8 <= POWER_MAX) txPower <= wr8;
               SEL_PIN_WAKE: pinWakeEnable <= {7'h00, wr8[0]};
               SEL_SILENCE: packetizeSilenceTimeout <= cfgData;
               SEL_RETRY: retryLimit <= wr8;
               SEL_BACKOFF: backoffSlotCount <= wr8;
               SEL_DATA_RATE: rfDataRate <= {7'h00, wr8[0]};
               SEL_DEST_ADDR: destinationAddress <= cfgData;
               SEL_IDLE_SLEEP: idleTimeBeforeSleep <= cfgData;
               SEL_SLEEP_MODE: sleepModeSelect <= wr8;
               default: ;
            endcase
         end
      end
   end

   logic [15:0] next_read;
   always_comb begin
      unique case (cfgReadSel)
         SEL_WAKE_INIT: next_read = {8'h00, wakeInitDuration};
         SEL_ADDR_MASK: next_read = addressMask;
         SEL_FORCED_RETX: next_read = {8'h00, forcedRetransmitCount};
         SEL_SRC_ADDR: next_read = sourceAddress;
         SEL_PARITY: next_read = {8'h00, uartParitySelect};
         SEL_MAX_PKT: next_read = maxPacketSize;
         SEL_TX_POWER: next_read = {8'h00, txPower};
         SEL_PIN_WAKE: next_read = {8'h00, pinWakeEnable};
         SEL_THRESHOLD: next_read = packetizeByteThreshold;
         SEL_SILENCE: next_read = packetizeSilenceTimeout;
         SEL_RETRY: next_read = {8'h00, retryLimit};
         SEL_BACKOFF: next_read = {8'h00, backoffSlotCount};
         SEL_DATA_RATE: next_read = {8'h00, rfDataRate};
         SEL_DEST_ADDR: next_read = destinationAddress;
         SEL_IDLE_SLEEP: next_read = idleTimeBeforeSleep;
         SEL_SLEEP_MODE: next_read = {8'h00, sleepModeSelect};
      endcase
   end

   // ==========================================
   // serial input buffer
   logic [7:0] bufMem [DEPTH];
   logic [12:0] wrPtr, rdPtr;
   wire [12:0] bufCount = wrPtr - rdPtr;
   wire bufEmpty = bufCount == 13'h0000;
   wire bufFull = bufCount == 13'(DEPTH);
   wire bufPush = serialByteValid && !bufFull;
   logic rdAdv;
   always_ff @(posedge sys_clk) begin
      if (bufPush) bufMem[wrPtr[11:0]] <= serialByte;
   end

   // silence timer in character times; restarts on each incoming byte
   logic [15:0] charCnt, silenceChars;
   wire charTick = charCnt == 16'(CHAR_CYCLES - 1);
   always_ff @(posedge sys_clk) begin
      if (!rstn || serialByteValid) begin
         charCnt <= 16'h0000;
         silenceChars <= 16'h0000;
      end else begin
         charCnt <= charTick ? 16'h0000 : charCnt + 16'h0001;
         if (charTick && silenceChars != 16'hffff) silenceChars <= silenceChars + 16'h0001;
      end
   end
   wire silenceMet = packetizeSilenceTimeout != 16'h0000 &&
                     silenceChars >= packetizeSilenceTimeout;
   wire thresholdMet = packetizeByteThreshold != 16'h0000 &&
                       {3'b000, bufCount} >= packetizeByteThreshold;
   wire startOk = !bufEmpty && (silenceMet || thresholdMet);

   // ==========================================
   // transmit control
   rfmpc_tx_e txState;
   logic streaming, sleeping;
   logic [31:0] timer;
   logic [15:0] pktBytes, pktStartPtr, pktLenHeld;
   logic [7:0] retxLeft;
   logic [31:0] holdCnt;
   wire forcedMode = forcedRetransmitCount != 8'h00;
   wire [15:0] pktLen = ({3'b000, bufCount} < maxPacketSize) ? {3'b000, bufCount} :
                        maxPacketSize;
   wire byteGo = rfByteValid && rfByteTaken;
   wire lastByte = byteGo && pktBytes == 16'h0001;
   // a zero-length packet would never reach its last byte, so it is never started
   wire txGo = holdCnt == 32'h0 && pktLen != 16'h0000 && ((streaming && !bufEmpty) || startOk);
   assign rdAdv = byteGo && retxLeft == 8'h00;
   wire [31:0] wakeCycles = wakeInitDuration * WAKE_UNIT;

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         txState <= TX_IDLE;
         streaming <= 1'b0;
         timer <= 32'h0;
         pktBytes <= 16'h0000;
         pktStartPtr <= 16'h0000;
         pktLenHeld <= 16'h0000;
         retxLeft <= 8'h00;
         rdPtr <= 13'h0000;
         rfByteValid <= 1'b0;
         rfPacketStart <= 1'b0;
         rfPacketEnd <= 1'b0;
         rfWakeInit <= 1'b0;
         rfAckRequest <= 1'b0;
      end else begin
         rfPacketStart <= 1'b0;
         rfPacketEnd <= 1'b0;
         unique case (txState)
            TX_IDLE: begin
               if (txGo) begin
                  pktBytes <= pktLen;
                  pktLenHeld <= pktLen;
                  pktStartPtr <= {3'b000, rdPtr};
                  retxLeft <= forcedRetransmitCount;
                  rfAckRequest <= !forcedMode && retryLimit != 8'h00;
                  if (sleeping || (!streaming && wakeInitDuration != 8'h00)) begin
                     txState <= TX_WAKE;
                     rfWakeInit <= 1'b1;
                     timer <= wakeCycles;
                  end else begin
                     txState <= TX_SEND;
                     rfPacketStart <= 1'b1;
                     rfByteValid <= 1'b1;
                  end
               end else if (bufEmpty) begin
                  streaming <= 1'b0;
               end
            end
            TX_WAKE: begin
               if (timer <= 32'h1) begin
                  rfWakeInit <= 1'b0;
                  txState <= TX_SEND;
                  rfPacketStart <= 1'b1;
                  rfByteValid <= 1'b1;
               end else begin
                  timer <= timer - 32'h1;
               end
            end
            TX_SEND: begin
               if (byteGo) begin
                  pktBytes <= pktBytes - 16'h0001;
                  if (rdAdv) rdPtr <= rdPtr + 13'h0001;
               end
               if (lastByte) begin
                  rfByteValid <= 1'b0;
                  rfPacketEnd <= 1'b1;
                  txState <= TX_GAP;
               end
            end
            TX_GAP: begin
               if (retxLeft != 8'h00) begin
                  retxLeft <= retxLeft - 8'h01;
                  pktBytes <= pktLenHeld;
                  rfPacketStart <= 1'b1;
                  rfByteValid <= 1'b1;
                  txState <= TX_SEND;
               end else begin
                  streaming <= 1'b1;
                  txState <= TX_IDLE;
               end
            end
            default: txState <= TX_IDLE;
         endcase
      end
   end
   // retransmissions replay from the packet start; the buffer is not drained until the last copy
   logic [11:0] pktOffset;
   assign rfByte = bufMem[pktStartPtr[11:0] + pktOffset];
   // cleared while nothing is offered, so a byte taken at once is still the first one
   always_ff @(posedge sys_clk) begin
      if (!rstn || !rfByteValid) pktOffset <= 12'h000;
      else if (byteGo) pktOffset <= pktOffset + 12'h001;
   end

   // ==========================================
   // receive filter and burst backoff
   wire [15:0] maskedDest = rxDestAddr & addressMask;
   wire addrHit = maskedDest == destinationAddress || maskedDest == addressMask;
   logic [15:0] lfsr;
   always_ff @(posedge sys_clk) begin
      if (!rstn) lfsr <= 16'hace1;
      else lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
   end
   // random slot pick spans 0..backoffSlotCount via modulo of lfsr
   wire [7:0] slotPick = (backoffSlotCount == 8'h00) ? 8'h00 :
                         8'(lfsr[7:0] % ({1'b0, backoffSlotCount} + 9'h001));
   wire [31:0] burstCycles = rxLength * rxRetxRemaining * CHAR_CYCLES;
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rxForward <= 1'b0;
         rxDiscard <= 1'b0;
         holdCnt <= 32'h0;
      end else begin
         rxForward <= rxHeader && addrHit;
         rxDiscard <= rxHeader && !addrHit;
         if (rxHeader && rxRetxRemaining != 8'h00)
            holdCnt <= burstCycles + slotPick * SLOT;
         else if (holdCnt != 32'h0)
            holdCnt <= holdCnt - 32'h1;
      end
   end

   // ==========================================
   // sleep and wake control
   wire cyclicMode = sleepModeSelect >= SLEEP_CYCLIC_MIN && sleepModeSelect <= SLEEP_CYCLIC_MAX;
   wire pinHold = cyclicMode && pinWakeEnable[0] && !sleepPin;
   wire busy = !bufEmpty || txState != TX_IDLE || serialByteValid;
   logic [31:0] idleCnt, msCnt, detectCnt;
   wire msTick = msCnt == 32'(MS_TICK - 1);
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         msCnt <= 32'h0;
         idleCnt <= 32'h0;
         detectCnt <= 32'h0;
         sleeping <= 1'b0;
         stayAwake <= 1'b1;
      end else begin
         msCnt <= msTick ? 32'h0 : msCnt + 32'h1;
         detectCnt <= rxWakeInit ? detectCnt + 32'h1 : 32'h0;
         if (!cyclicMode || pinHold || busy || rxHeader) begin
            idleCnt <= 32'h0;
            sleeping <= 1'b0;
         end else if (sleeping) begin
            if (detectCnt >= 32'(WAKE_DETECT)) begin
               sleeping <= 1'b0;
               idleCnt <= 32'h0;
            end
         end else if (msTick) begin
            if (idleCnt >= {16'h0000, idleTimeBeforeSleep}) sleeping <= 1'b1;
            else idleCnt <= idleCnt + 32'h1;
         end
         stayAwake <= !sleeping;
      end
   end

   // ==========================================
   // registered outputs and the buffer write pointer
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         cfgReadData <= 16'h0000;
         warningFlags <= 8'h00;
         serialReady <= 1'b0;
         wrPtr <= 13'h0000;
         rfSourceAddr <= RST_SRC_ADDR;
         rfDestAddr <= RST_DEST_ADDR;
         rfRetxRemaining <= 8'h00;
         cyclicSleep <= 1'b0;
         uartParityMode <= 3'h0;
         txPowerLevel <= 3'h4;
      end else begin
         cfgReadData <= next_read;
         if (rateToZero && maxPacketSize > PKT_CAP_LOW) warningFlags[0] <= 1'b1;
         else if (cfgWrite && cfgSel == SEL_MAX_PKT) warningFlags[0] <= 1'b0;
         serialReady <= bufCount < 13'(DEPTH - 2);
         if (bufPush) wrPtr <= wrPtr + 13'h0001;
         rfSourceAddr <= (sourceAddress == RST_SRC_ADDR) ? destinationAddress : sourceAddress;
         rfDestAddr <= destinationAddress;
         rfRetxRemaining <= retxLeft;
         cyclicSleep <= sleeping;
         uartParityMode <= uartParitySelect[2:0];
         txPowerLevel <= txPower[2:0];
      end
   end
endmodule

/* File: rfmpc_rf_sink.sv */
/* rfmpc_rf_sink: modulator model that paces rf bytes.
 assumes rfByteValid holds until taken. */
`timescale 1ns/1ps
module rfmpc_rf_sink (
   input wire logic sys_clk,
   input wire logic slow,
   input wire logic rfByteValid,
   output logic rfByteTaken
);
   logic phase = 1'b0;
   // ==========
   // slow mode stalls every other cycle
   always @(posedge sys_clk) begin
      phase <= !phase;
      rfByteTaken <= rfByteValid && (!slow || phase);
   end
endmodule

/* File: rfmpc_monitor.sv */
/* rfmpc_monitor: port assertions for rfmpc_top.
 assumes one clock domain, rstn sync active low. */
`timescale 1ns/1ps
module rfmpc_monitor (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic factoryDefaultLoad,
   input wire logic rfByteTaken,
   input wire logic rxHeader,
   input wire logic rfByteValid,
   input wire logic [7:0] rfByte,
   input wire logic rfPacketStart,
   input wire logic rfPacketEnd,
   input wire logic rfAckRequest,
   input wire logic rfWakeInit,
   input wire logic [7:0] rfRetxRemaining,
   input wire logic rxForward,
   input wire logic rxDiscard,
   input wire logic [2:0] uartParityMode,
   input wire logic [2:0] txPowerLevel
);
   // ==========
   // assertions
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   rx_verdict_a: assert property (rxHeader |=> rxForward != rxDiscard)
      else $error("rx header without one verdict");
   rx_quiet_a: assert property (!rxHeader |=> !rxForward && !rxDiscard)
      else $error("rx verdict without header");
   parity_range_a: assert property (uartParityMode <= 3'h4)
      else $error("parity mode out of range");
   power_range_a: assert property (txPowerLevel <= 3'h4)
      else $error("power level out of range");
   end_gap_a: assert property (rfPacketEnd |-> !rfByteValid && !rfPacketStart)
      else $error("no idle gap after packet");
   retx_noack_a: assert property (rfRetxRemaining != 8'h00 |-> !rfAckRequest)
      else $error("ack requested in forced burst");
   byte_hold_a: assert property (rfByteValid && !rfByteTaken |=> rfByteValid && $stable(rfByte))
      else $error("rf byte dropped before taken");
   wake_quiet_a: assert property (rfWakeInit |-> !rfByteValid)
      else $error("data during wake initializer");
   restore_dflt_a: assert property (factoryDefaultLoad |-> ##[1:2] txPowerLevel == 3'h4 && uartParityMode == 3'h0)
      else $error("defaults not restored");
   // ==========
   // covers
   cover property (rfPacketStart);
   cover property (rxForward);
   cover property (rfWakeInit);
endmodule
bind rfmpc_top rfmpc_monitor u_rfmpc_monitor (.*);

/* File: rf_modem_packet_control_test.sv */
/* rf_modem_packet_control_test: self-checking bench for rfmpc_top.
 assumes shortened timing parameters and the rf sink model. */
`timescale 1ns/1ps
module rf_modem_packet_control_test;
   import rfmpc_pkg::*;
   localparam int WU = 10;
   localparam logic [15:0] M = 16'h00ff;
   localparam logic [15:0] D = 16'h0012;
   logic sys_clk = 1'b0, rstn = 1'b0, cfgWrite = 1'b0, factoryDefaultLoad = 1'b0;
   logic [3:0] cfgSel = 4'h0, cfgReadSel = 4'h0;
   logic [15:0] cfgData = 16'h0000, cfgReadData, rfSourceAddr, rfDestAddr;
   logic [15:0] rxDestAddr = 16'h0000, rxLength = 16'h0000;
   logic [7:0] warningFlags, serialByte = 8'h00, rfByte, rfRetxRemaining;
   logic [7:0] rxRetxRemaining = 8'h00;
   logic serialByteValid = 1'b0, serialReady, rfByteValid, rfPacketStart, rfPacketEnd;
   logic rfAckRequest, rfWakeInit, rfByteTaken, rxHeader = 1'b0, rxWakeInit = 1'b0;
   logic rxForward, rxDiscard, sleepPin = 1'b1, stayAwake, cyclicSleep, slow = 1'b1;
   logic [2:0] uartParityMode, txPowerLevel;
   int n_errors = 0, checked = 0, cyc = 0, starts = 0, bytes = 0, wakes = 0, acks = 0;
   logic [15:0] dflt [9] = '{16'h0001, 16'hffff, 16'h0000, 16'hffff, 16'h0000,
      16'h0800, 16'h0004, 16'h0000, 16'h0800};
   logic [15:0] ra [3] = '{16'hab12, 16'h0013, 16'h34ff};
   logic [7:0] sent [9] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h30, 8'h31, 8'h32, 8'h33, 8'h41};
   // row: write select, write data, read select, expected read
   logic [39:0] rows [10] = '{40'h4000340003, 40'h4000540003, 40'h6000060000,
      40'h6000960000, 40'h8010080100, 40'h5004080040, 40'h5090050800,
      40'hc000050100, 40'hc000150100, 40'h3123431234};
   rfmpc_top #(.WAKE_UNIT(WU), .WAKE_DETECT(4), .SLOT(5), .MS_TICK(2), .CHAR_CYCLES(4))
      u_rfmpc_top (.*);
   rfmpc_rf_sink u_rfmpc_rf_sink (.*);
   always #10 sys_clk = !sys_clk;
   // ==========
   // traffic counters and hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      starts <= starts + int'(rfPacketStart);
      bytes <= bytes + int'(rfByteValid && rfByteTaken);
      wakes <= wakes + int'(rfWakeInit);
      acks <= acks + int'(rfAckRequest);
      if (rfByteValid && rfByteTaken && bytes < 9)
         chk("rf byte", {8'h00, rfByte}, {8'h00, sent[bytes]});
      if (cyc == 20000) begin
         n_errors++;
         finish_test();
      end
   end
   // ==========
   // tasks
   task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr(logic [3:0] s, logic [15:0] d);
      @(posedge sys_clk);
      cfgWrite <= 1'b1;
      cfgSel <= s;
      cfgData <= d;
      @(posedge sys_clk);
      cfgWrite <= 1'b0;
   endtask
   task automatic rd(logic [3:0] s, logic [15:0] e);
      @(posedge sys_clk);
      cfgReadSel <= s;
      repeat (2) @(posedge sys_clk);
      #1 chk("cfg read", cfgReadData, e);
   endtask
   task automatic rx(logic [15:0] a, logic e);
      @(posedge sys_clk);
      rxHeader <= 1'b1;
      rxDestAddr <= a;
      @(posedge sys_clk);
      rxHeader <= 1'b0;
      #1 chk("rx forward", {15'h0, rxForward}, {15'h0, e});
      chk("rx discard", {15'h0, rxDiscard}, {15'h0, !e});
   endtask
   task automatic finish_test();
      $display("errors %0d checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========
   // main sequence
   initial begin
      repeat (3) @(posedge sys_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         rd(4'(i), dflt[i]);
      end
      chk("tx power", {13'h0, txPowerLevel}, 16'h0004);
      chk("serial ready", {15'h0, serialReady}, 16'h0001);
      for (int i = 0; i < 10; i++) begin
         wr(rows[i][39:36], rows[i][35:20]);
         rd(rows[i][19:16], rows[i][15:0]);
      end
      chk("warning", {8'h00, warningFlags}, 16'h0001);
      chk("parity", {13'h0, uartParityMode}, 16'h0003);
      chk("source addr", rfSourceAddr, 16'h1234);
      wr(SEL_ADDR_MASK, M);
      wr(SEL_DEST_ADDR, D);
      for (int i = 0; i < 3; i++) begin
         rx(ra[i], ((ra[i] & M) == D) || ((ra[i] & M) == M));
      end
      // one unit stays above the receivers' sleep interval
      wr(SEL_WAKE_INIT, 16'h0001);
      wr(SEL_FORCED_RETX, 16'h0001);
      wr(SEL_RETRY, 16'h0005);
      wr(SEL_SILENCE, 16'h0000);
      wr(SEL_THRESHOLD, 16'h0004);
      for (int i = 0; i < 4; i++) begin
         @(posedge sys_clk);
         serialByteValid <= 1'b1;
         serialByte <= 8'(i + 8'h30);
      end
      @(posedge sys_clk);
      serialByteValid <= 1'b0;
      for (int i = 0; i < 400 && bytes < 8; i++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      chk("packets", 16'(starts), 16'h0002);
      chk("rf bytes", 16'(bytes), 16'h0008);
      chk("wake cycles", 16'(wakes), 16'(WU));
      chk("ack requests", 16'(acks), 16'h0000);
      @(posedge sys_clk);
      factoryDefaultLoad <= 1'b1;
      @(posedge sys_clk);
      factoryDefaultLoad <= 1'b0;
      rd(SEL_PARITY, 16'h0000);
      rd(SEL_MAX_PKT, 16'h0800);
      wr(SEL_DEST_ADDR, D);
      rd(SEL_DEST_ADDR, D);
      chk("source addr", rfSourceAddr, D);
      chk("dest addr", rfDestAddr, D);
      // silence alone starts a one-byte packet; no forced copies, so ack is asked
      @(posedge sys_clk);
      serialByteValid <= 1'b1;
      serialByte <= 8'h41;
      @(posedge sys_clk);
      serialByteValid <= 1'b0;
      for (int i = 0; i < 100 && bytes < 9; i++) @(posedge sys_clk);
      repeat (2) @(posedge sys_clk);
      chk("rf bytes", 16'(bytes), 16'h0009);
      chk("packets", 16'(starts), 16'h0003);
      chk("ack requested", {15'h0, acks != 0}, 16'h0001);
      // pin low keeps the modem out of cyclic sleep
      @(posedge sys_clk);
      sleepPin <= 1'b0;
      wr(SEL_SLEEP_MODE, 16'h0004);
      wr(SEL_PIN_WAKE, 16'h0001);
      wr(SEL_IDLE_SLEEP, 16'h0002);
      repeat (20) @(posedge sys_clk);
      #1 chk("cyclic sleep", {15'h0, cyclicSleep}, 16'h0000);
      @(posedge sys_clk);
      sleepPin <= 1'b1;
      repeat (20) @(posedge sys_clk);
      #1 chk("cyclic sleep", {15'h0, cyclicSleep}, 16'h0001);
      @(posedge sys_clk);
      rxWakeInit <= 1'b1;
      for (int i = 0; i < 10 && !stayAwake; i++) @(posedge sys_clk);
      #1 chk("stay awake", {15'h0, stayAwake}, 16'h0001);
      finish_test();
   end
endmodule
